// [hdl/extended_memory_op_datapath.sv]
`timescale 1ns/10ps
// Functional notes
// - increment byte, write back, zero only
// - byte plus one to accumulator, zero only
// - byte copied to accumulator, flags kept
// - accumulator written to byte, flags kept
// - accumulator or byte into accumulator, zero
// - accumulator or byte into byte, zero
// - rotate byte left circularly, flags kept
// - circular left rotate into accumulator, flags kept
// - rotate byte left through carry, write back
// - carry rotate into accumulator, byte kept
module extended_memory_op_datapath
   import xmem_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int ADDR_W = ADDR_W_DEF
)
(
   // clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_rstn,
   // decoder request
   input  wire logic              i_op_valid,
   input  wire logic [3:0]        i_op_code,
   input  wire logic [ADDR_W-1:0] i_op_addr,
   // core side accumulator and flag loads
   input  wire logic              i_acc_wr,
   input  wire logic [DATA_W-1:0] i_acc_wdata,
   input  wire logic              i_flag_wr,
   input  wire logic              i_zero_wdata,
   input  wire logic              i_carry_wdata,
   // data memory
   input  wire logic [DATA_W-1:0] i_mem_rdata,
   output logic       [ADDR_W-1:0] o_mem_addr,
   output logic                    o_mem_rd,
   output logic                    o_mem_we,
   output logic       [DATA_W-1:0] o_mem_wdata,
   // status
   output logic       [DATA_W-1:0] o_accumulator,
   output logic                    o_zero_flag,
   output logic                    o_carry_flag,
   output logic                    o_busy,
   output logic                    o_done
);

   // rotate checks index bits 7 and 6:0, so they assume a byte wide datapath
   if (DATA_W != 8 || ADDR_W < 1)
   begin : g_bad_param
      $error("extended_memory_op_datapath: DATA_W must be 8, ADDR_W at least 1");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   state_t              st_q, st_d;
   op_t                 op_q;
   logic [ADDR_W-1:0]   addr_q;
   logic [DATA_W-1:0]   acc_q;
   logic                zero_q, carry_q;
   logic                rd_q, we_q, done_q, busy_q;
   logic [DATA_W-1:0]   wdata_q;

   logic [DATA_W-1:0]   alu_res;
   logic                alu_to_mem, alu_to_acc, alu_upd_z, alu_upd_c, alu_c;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // unknown codes are dropped rather than guessed at
   wire logic start_w   = (st_q == st_idle) && i_op_valid && (i_op_code <= OP_LAST);
   wire logic skip_rd_w = (op_t'(i_op_code) == extended_move_to_mem_op);
   wire logic exec_w    = (st_q == st_exec);
   // core loads only land while idle so they never race a result
   wire logic core_ok_w = (st_q == st_idle) && !start_w;
   // acc-to-mem moves read nothing back for the write path
   wire logic [DATA_W-1:0] mem_w = exec_w ? i_mem_rdata : '0;

   xmem_alu #(
      .DATA_W (DATA_W)
   ) u_alu (
      .i_op        (op_q),
      .i_mem       (mem_w),
      .i_acc       (acc_q),
      .i_carry     (carry_q),
      .o_res       (alu_res),
      .o_to_mem    (alu_to_mem),
      .o_to_acc    (alu_to_acc),
      .o_upd_zero  (alu_upd_z),
      .o_upd_carry (alu_upd_c),
      .o_carry     (alu_c)
   );

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         st_idle: if (start_w) st_d = skip_rd_w ? st_exec : st_read;
         st_read: st_d = st_exec;
         st_exec: st_d = st_idle;
         default: st_d = st_idle;
      endcase
   end

   // ----------------------------------------
   // sequencer and request capture
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_q   <= st_idle;
         op_q   <= mem_increment_op;
         addr_q <= '0;
         rd_q   <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         rd_q <= start_w && !skip_rd_w;
         // busy from the next state so the pin is a flop, same timing as the state
         busy_q <= (st_d != st_idle);
         if (start_w)
         begin
            op_q   <= op_t'(i_op_code);
            addr_q <= i_op_addr;
         end
      end
   end

   // ----------------------------------------
   // results
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         acc_q   <= ACC_RST;
         zero_q  <= ZERO_RST;
         carry_q <= CARRY_RST;
         we_q    <= 1'b0;
         wdata_q <= '0;
         done_q  <= 1'b0;
      end
      else
      begin
         we_q   <= exec_w && alu_to_mem;
         done_q <= exec_w;
         if (exec_w && alu_to_mem)
            wdata_q <= alu_res;
         if (exec_w && alu_to_acc)
            acc_q <= alu_res;
         else if (core_ok_w && i_acc_wr)
            acc_q <= i_acc_wdata;
         if (exec_w && alu_upd_z)
            zero_q <= (alu_res == '0);
         else if (core_ok_w && i_flag_wr)
            zero_q <= i_zero_wdata;
         if (exec_w && alu_upd_c)
            carry_q <= alu_c;
         else if (core_ok_w && i_flag_wr)
            carry_q <= i_carry_wdata;
      end
   end

   assign o_mem_addr    = addr_q;
   assign o_mem_rd      = rd_q;
   assign o_mem_we      = we_q;
   assign o_mem_wdata   = wdata_q;
   assign o_accumulator = acc_q;
   assign o_zero_flag   = zero_q;
   assign o_carry_flag  = carry_q;
   assign o_busy        = busy_q;
   assign o_done        = done_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_ex(op_t o);
      exec_w && (op_q == o);
   endsequence

   sequence s_read_path;
      rd_q && (st_q == st_read) ##1 exec_w ##1 done_q;
   endsequence

   property p_read_path;
      @(posedge i_mclk) disable iff (!i_rstn)
      (start_w && !skip_rd_w) |=> s_read_path;
   endproperty
   a_read_path: assert property (p_read_path) else $error("read sequence broken");

   property p_inc;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(mem_increment_op) |=> we_q && (wdata_q == DATA_W'($past(i_mem_rdata) + 1'b1))
                                 && $stable(carry_q) && $stable(acc_q);
   endproperty
   a_inc: assert property (p_inc) else $error("increment write back wrong");

   property p_inca;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(mem_increment_to_acc_op) |=> !we_q && (acc_q == DATA_W'($past(i_mem_rdata) + 1'b1))
                                        && $stable(carry_q);
   endproperty
   a_inca: assert property (p_inca) else $error("increment to acc wrong");

   property p_mova;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(extended_move_to_acc_op) |=> !we_q && (acc_q == $past(i_mem_rdata))
                                        && $stable(zero_q) && $stable(carry_q);
   endproperty
   a_mova: assert property (p_mova) else $error("move to acc wrong");

   property p_movm;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(extended_move_to_mem_op) |=> we_q && (wdata_q == acc_q) && $stable(acc_q)
                                        && $stable(zero_q) && $stable(carry_q);
   endproperty
   a_movm: assert property (p_movm) else $error("move to mem wrong");

   property p_ora;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(or_into_acc_op) |=> !we_q && (acc_q == ($past(acc_q) | $past(i_mem_rdata)));
   endproperty
   a_ora: assert property (p_ora) else $error("or to acc wrong");

   property p_orm;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(or_into_mem_op) |=> we_q && (wdata_q == (acc_q | $past(i_mem_rdata)))
                               && $stable(acc_q);
   endproperty
   a_orm: assert property (p_orm) else $error("or to mem wrong");

   property p_rl;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(rotate_left_op) |=> we_q && (wdata_q == {$past(i_mem_rdata[6:0]),
                               $past(i_mem_rdata[7])}) && $stable(carry_q) && $stable(zero_q);
   endproperty
   a_rl: assert property (p_rl) else $error("rotate left wrong");

   property p_rla;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(rotate_left_to_acc_op) |=> !we_q && (acc_q == {$past(i_mem_rdata[6:0]),
                                      $past(i_mem_rdata[7])}) && $stable(carry_q);
   endproperty
   a_rla: assert property (p_rla) else $error("rotate left to acc wrong");

   property p_rlc;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(rotate_left_carry_op) |=> we_q && (wdata_q == {$past(i_mem_rdata[6:0]),
                                     $past(carry_q)}) && (carry_q == $past(i_mem_rdata[7]));
   endproperty
   a_rlc: assert property (p_rlc) else $error("rotate through carry wrong");

   property p_rlca;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ex(rotate_left_carry_to_acc_op) |=> !we_q && (carry_q == $past(i_mem_rdata[7]))
                                  && (acc_q == {$past(i_mem_rdata[6:0]), $past(carry_q)});
   endproperty
   a_rlca: assert property (p_rlca) else $error("carry rotate to acc wrong");

   property p_zero;
      @(posedge i_mclk) disable iff (!i_rstn)
      (exec_w && alu_upd_z) |=> (zero_q == ($past(alu_res) == '0)) ##1 !done_q;
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule // extended_memory_op_datapath

// [hdl/xmem_alu.sv]
`timescale 1ns/10ps
module xmem_alu
   import xmem_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF
)
(
   // operands
   input  wire op_t               i_op,
   input  wire logic [DATA_W-1:0] i_mem,
   input  wire logic [DATA_W-1:0] i_acc,
   input  wire logic              i_carry,
   // results
   output logic       [DATA_W-1:0] o_res,
   output logic                    o_to_mem,
   output logic                    o_to_acc,
   output logic                    o_upd_zero,
   output logic                    o_upd_carry,
   output logic                    o_carry
);

   // rotates need at least two bits to move
   if (DATA_W < 2)
   begin : g_bad_width
      $error("xmem_alu: DATA_W must be at least 2");
   end

   // ----------------------------------------
   // operand paths
   // ----------------------------------------
   wire logic [DATA_W-1:0] inc_w = DATA_W'(i_mem + 1'b1);
   wire logic [DATA_W-1:0] or_w  = i_acc | i_mem;
   wire logic [DATA_W-1:0] rl_w  = {i_mem[DATA_W-2:0], i_mem[DATA_W-1]};
   wire logic [DATA_W-1:0] rlc_w = {i_mem[DATA_W-2:0], i_carry};

   always_comb
   begin
      o_res       = i_mem;
      o_to_mem    = 1'b0;
      o_to_acc    = 1'b0;
      o_upd_zero  = 1'b0;
      o_upd_carry = 1'b0;
      o_carry     = i_carry;
      case (i_op)
         mem_increment_op:
         begin
            o_res      = inc_w;
            o_to_mem   = 1'b1;
            o_upd_zero = 1'b1;
         end
         mem_increment_to_acc_op:
         begin
            o_res      = inc_w;
            o_to_acc   = 1'b1;
            o_upd_zero = 1'b1;
         end
         extended_move_to_acc_op:
         begin
            o_to_acc = 1'b1;
         end
         extended_move_to_mem_op:
         begin
            o_res    = i_acc;
            o_to_mem = 1'b1;
         end
         or_into_acc_op:
         begin
            o_res      = or_w;
            o_to_acc   = 1'b1;
            o_upd_zero = 1'b1;
         end
         or_into_mem_op:
         begin
            o_res      = or_w;
            o_to_mem   = 1'b1;
            o_upd_zero = 1'b1;
         end
         rotate_left_op:
         begin
            o_res    = rl_w;
            o_to_mem = 1'b1;
         end
         rotate_left_to_acc_op:
         begin
            o_res    = rl_w;
            o_to_acc = 1'b1;
         end
         rotate_left_carry_op:
         begin
            o_res       = rlc_w;
            o_to_mem    = 1'b1;
            o_upd_carry = 1'b1;
            o_carry     = i_mem[DATA_W-1];
         end
         rotate_left_carry_to_acc_op:
         begin
            o_res       = rlc_w;
            o_to_acc    = 1'b1;
            o_upd_carry = 1'b1;
            o_carry     = i_mem[DATA_W-1];
         end
         default:
         begin
            o_res = i_mem;
         end
      endcase
   end

endmodule // xmem_alu

// [hdl/xmem_pkg.sv]
package xmem_pkg;

   // ----------------------------------------
   // widths and reset values
   // ----------------------------------------
   localparam int          DATA_W_DEF = 8;
   localparam int          ADDR_W_DEF = 8;
   localparam logic [7:0]  ACC_RST    = 8'h00;
   localparam logic        ZERO_RST   = 1'b0;
   localparam logic        CARRY_RST  = 1'b0;
   // memory read data is valid this many cycles after the read strobe
   localparam int          RD_LAT     = 1;

   // ----------------------------------------
   // operation codes
   // ----------------------------------------
   typedef enum logic [3:0] {
      mem_increment_op            = 4'h0,
      mem_increment_to_acc_op     = 4'h1,
      extended_move_to_acc_op     = 4'h2,
      extended_move_to_mem_op     = 4'h3,
      or_into_acc_op              = 4'h4,
      or_into_mem_op              = 4'h5,
      rotate_left_op              = 4'h6,
      rotate_left_to_acc_op       = 4'h7,
      rotate_left_carry_op        = 4'h8,
      rotate_left_carry_to_acc_op = 4'h9
   } op_t;

   localparam logic [3:0]  OP_LAST    = 4'h9;

   // ----------------------------------------
   // sequencer states, gray along idle-read-exec
   // ----------------------------------------
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_read = 2'b01,
      st_exec = 2'b11
   } state_t;

endpackage

// [tb/extended_memory_op_datapath_bench.sv]
`timescale 1ns/10ps
`define check_eq(got, exp) \
   begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module extended_memory_op_datapath_bench;
   import xmem_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic       i_mclk = 1'b0;
   logic       i_rstn = 1'b0;
   logic       i_op_valid = 1'b0;
   logic [3:0] i_op_code = 4'h0;
   logic [7:0] i_op_addr = 8'h00;
   logic       i_acc_wr = 1'b0;
   logic [7:0] i_acc_wdata = 8'h00;
   logic       i_flag_wr = 1'b0;
   logic       i_zero_wdata = 1'b0;
   logic       i_carry_wdata = 1'b0;
   logic [7:0] mem_rdata, mem_addr, mem_wdata, acc;
   logic       mem_rd, mem_we, zf, cf, busy, done;
   int         mismatches = 0;
   int         check_count = 0;
   int         cycles = 0;

   extended_memory_op_datapath dut (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_op_valid(i_op_valid), .i_op_code(i_op_code),
      .i_op_addr(i_op_addr), .i_acc_wr(i_acc_wr), .i_acc_wdata(i_acc_wdata),
      .i_flag_wr(i_flag_wr), .i_zero_wdata(i_zero_wdata), .i_carry_wdata(i_carry_wdata),
      .i_mem_rdata(mem_rdata), .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .o_mem_we(mem_we),
      .o_mem_wdata(mem_wdata), .o_accumulator(acc), .o_zero_flag(zf), .o_carry_flag(cf),
      .o_busy(busy), .o_done(done));

   xmem_mem_model mem_i (
      .i_mclk(i_mclk), .i_addr(mem_addr), .i_rd(mem_rd), .i_we(mem_we),
      .i_wdata(mem_wdata), .o_rdata(mem_rdata));

   // ----------------------------------------
   // clock and timeout
   // ----------------------------------------
   initial
      forever #50 i_mclk = ~i_mclk;

   // the whole run needs about 80 cycles
   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         test_done();
      end
   end

   task automatic test_done();
      $display("mismatches %0d, checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // shared operation cycle
   // ----------------------------------------
   // seeds acc and flags, preloads the byte, runs one op and compares all results
   task automatic do_op(input logic [3:0] code, input logic [7:0] addr, m, a,
                        input logic z, c, input logic [7:0] em, ea, input logic ez, ec,
                        input int lat);
      int   n;
      logic wr;
      wr = code inside {4'h0, 4'h3, 4'h5, 4'h6, 4'h8};
      @(posedge i_mclk);
      i_acc_wr <= 1'b1;
      i_acc_wdata <= a;
      i_flag_wr <= 1'b1;
      i_zero_wdata <= z;
      i_carry_wdata <= c;
      @(posedge i_mclk);
      i_acc_wr <= 1'b0;
      i_flag_wr <= 1'b0;
      i_op_valid <= 1'b1;
      i_op_code <= code;
      i_op_addr <= addr;
      #1 mem_i.mem_q[addr] = m;
      @(posedge i_mclk);
      i_op_valid <= 1'b0;
      #1 n = 0;
      `check_eq(busy, 1'b1)
      `check_eq(mem_rd, lat == 2)
      while (done !== 1'b1 && n < 8)
      begin
         @(posedge i_mclk);
         #1 n++;
      end
      `check_eq(n, lat)
      `check_eq(acc, ea)
      `check_eq(zf, ez)
      `check_eq(cf, ec)
      `check_eq(mem_addr, addr)
      `check_eq(busy, 1'b0)
      `check_eq(mem_we, wr)
      if (wr)
         `check_eq(mem_wdata, em)
      @(posedge i_mclk);
      #1 `check_eq(mem_i.mem_q[addr], em)
      `check_eq(done, 1'b0)
      `check_eq(mem_we, 1'b0)
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // wrap to zero, carry kept
   task automatic t_inc(); do_op(4'h0, 8'h10, 8'hff, 8'h5a, 0, 1, 8'h00, 8'h5a, 1, 1, 2);
   endtask
   task automatic t_inc_acc(); do_op(4'h1, 8'h11, 8'h7f, 8'h00, 1, 0, 8'h7f, 8'h80, 0, 0, 2);
   endtask
   task automatic t_mov_acc(); do_op(4'h2, 8'h12, 8'h00, 8'h33, 0, 1, 8'h00, 8'h00, 0, 1, 2);
   endtask
   task automatic t_mov_mem(); do_op(4'h3, 8'hff, 8'h00, 8'hc3, 1, 0, 8'hc3, 8'hc3, 1, 0, 1);
   endtask
   task automatic t_or_acc(); do_op(4'h4, 8'h00, 8'h00, 8'h00, 0, 1, 8'h00, 8'h00, 1, 1, 2);
   endtask
   task automatic t_or_mem(); do_op(4'h5, 8'h14, 8'ha0, 8'h0f, 1, 1, 8'haf, 8'h0f, 0, 1, 2);
   endtask
   // top bit wraps to bit 0
   task automatic t_rl(); do_op(4'h6, 8'h15, 8'h81, 8'h44, 1, 0, 8'h03, 8'h44, 1, 0, 2);
   endtask
   task automatic t_rla(); do_op(4'h7, 8'h16, 8'h80, 8'h44, 0, 1, 8'h80, 8'h01, 0, 1, 2);
   endtask
   // bit 7 into carry, old carry in
   task automatic t_rlc(); do_op(4'h8, 8'h17, 8'h80, 8'h44, 0, 0, 8'h00, 8'h44, 0, 1, 2);
   endtask
   task automatic t_rlca(); do_op(4'h9, 8'h18, 8'h41, 8'h00, 1, 1, 8'h41, 8'h83, 1, 0, 2);
   endtask

   // core loads and a second request are refused while busy
   task automatic t_busy_refuse();
      @(posedge i_mclk);
      i_op_valid <= 1'b1;
      i_op_code <= 4'h4;
      i_op_addr <= 8'h18;
      i_acc_wr <= 1'b1;
      i_acc_wdata <= 8'h00;
      i_flag_wr <= 1'b1;
      i_zero_wdata <= 1'b1;
      i_carry_wdata <= 1'b1;
      @(posedge i_mclk);
      i_op_code <= 4'h3;
      @(posedge i_mclk);
      i_op_valid <= 1'b0;
      i_acc_wr <= 1'b0;
      i_flag_wr <= 1'b0;
      @(posedge i_mclk);
      #1 `check_eq(done, 1'b1)
      `check_eq(acc, 8'hc3)
      `check_eq(zf, 1'b0)
      `check_eq(cf, 1'b0)
      @(posedge i_mclk);
      #1 `check_eq(busy, 1'b0)
      `check_eq(mem_we, 1'b0)
   endtask

   // reset in mid operation clears outputs and drops the request
   task automatic t_reset_mid();
      @(posedge i_mclk);
      i_op_valid <= 1'b1;
      i_op_code <= 4'h1;
      i_op_addr <= 8'h18;
      @(posedge i_mclk);
      i_op_valid <= 1'b0;
      i_rstn <= 1'b0;
      #1 `check_eq({busy, mem_rd, acc}, 10'h000)
      repeat (2) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      #1 `check_eq({busy, mem_rd, done, mem_we}, 4'h0)
      `check_eq(acc, ACC_RST)
   endtask

   // unused codes never start the sequencer
   task automatic t_bad_code();
      @(posedge i_mclk);
      i_op_valid <= 1'b1;
      i_op_code <= 4'ha;
      @(posedge i_mclk);
      i_op_valid <= 1'b0;
      @(posedge i_mclk);
      #1 `check_eq(busy, 1'b0)
      `check_eq(mem_rd, 1'b0)
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge i_mclk);
      i_rstn <= 1'b1;
      #1 `check_eq(acc, ACC_RST)
      t_inc();
      t_inc_acc();
      t_mov_acc();
      t_mov_mem();
      t_or_acc();
      t_or_mem();
      t_rl();
      t_rla();
      t_rlc();
      t_rlca();
      t_busy_refuse();
      t_reset_mid();
      t_bad_code();
      test_done();
   end
endmodule // extended_memory_op_datapath_bench

// [tb/xmem_mem_model.sv]
`timescale 1ns/10ps
module xmem_mem_model
(
   // clock
   input  wire logic       i_mclk,
   // memory port of the datapath
   input  wire logic [7:0] i_addr,
   input  wire logic       i_rd,
   input  wire logic       i_we,
   input  wire logic [7:0] i_wdata,
   // read data, one cycle after the strobe
   output logic      [7:0] o_rdata
);
   // ----------------------------------------
   // storage and read port
   // ----------------------------------------
   logic [7:0] mem_q [0:255];

   initial
      o_rdata = 8'h00;

   // a released bus inverts its value every cycle, so stale data only reappears on every second cycle
   always @(posedge i_mclk)
   begin
      if (i_we)
         mem_q[i_addr] <= i_wdata;
      if (i_rd)
         o_rdata <= mem_q[i_addr];
      else
         o_rdata <= ~o_rdata;
   end
endmodule // xmem_mem_model
